// ===== isp_pkg.sv
// isp_pkg: constants for the slave audio serial port
// assumes a 25 MHz system clock; all link timing is counted in its cycles
package isp_pkg;

  // system clock period in ns
  localparam int CLK_NS = 40;

  // format select: normal framing codes and their range
  localparam logic [3:0] FMT_FIRST = 4'h2;
  localparam logic [3:0] FMT_LAST  = 4'hd;

  // sample rate codes 0..8
  localparam logic [3:0] RATE_LAST = 4'h8;

  // frame layout: 32 bit clocks, two 16-bit slots
  localparam int SLOT_BITS  = 16;
  localparam int FRAME_BITS = 32;

  // least bit clock period per rate code, in ns (256 kHz .. 1536 kHz)
  localparam int BCLK_MIN_NS [0:8] = '{3906, 2834, 2604, 1953, 1417, 1302, 977, 709, 651};

  // least word alignment period per rate code, in ns (8 kHz .. 48 kHz)
  localparam int WS_MIN_NS [0:8] = '{125000, 90700, 83330, 62500, 45350, 41670, 31250,
                                     22680, 20830};

  // period counter width, enough for the longest least frame period
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] CNT_MAX = 12'hfff;

  // least time to whole cycles, rounded up, never below one
  function automatic logic [CNT_W-1:0] ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    if (c < 1) begin
      c = 1;
    end
    return c[CNT_W-1:0];
  endfunction

endpackage

// ===== isp_edge_sync.sv
// isp_edge_sync: two-flop synchroniser with edge detection for one pin
// assumes din is asynchronous to mclk; rise/fall are one-cycle pulses
`timescale 1ns/1ns
`default_nettype none
module isp_edge_sync (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic din,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta;
  logic stable;
  logic prev;
  logic [2:0] fill;

  // first stage feeds only the second stage
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta   <= 1'b0;
      stable <= 1'b0;
      prev   <= 1'b0;
      fill   <= 3'b000;
    end else begin
      fill   <= {fill[1:0], 1'b1};
      meta   <= din;
      stable <= meta;
      prev   <= stable;
    end
  end

  // edges seen on the settled level only; masked until prev holds a real
  // pin sample, since a pin idling high would otherwise fake a rise after reset
  assign level = stable;
  assign rise  = stable & ~prev & fill[2];
  assign fall  = ~stable & prev & fill[2];

endmodule
`default_nettype wire

// ===== isp_audio_slave.sv
// isp_audio_slave: slave audio serial port, normal framing, external bit clock
// assumes the master drives bit clock and word select; all pins are sampled by mclk
//
// Functional notes
// - even format codes launch transmit bits on the bit clock falling edge.
// - odd format codes launch transmit bits on the bit clock rising edge.
// - even format codes sample receive bits on the bit clock rising edge.
// - odd format codes sample receive bits on the bit clock falling edge.
`timescale 1ns/1ns
`default_nettype none
module isp_audio_slave
  import isp_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        bitClk,
  input  wire logic        wordSel,
  input  wire logic        rxPin,
  input  wire logic [3:0]  formatCode,
  input  wire logic [3:0]  rateCode,
  input  wire logic [15:0] txLeft,
  input  wire logic [15:0] txRight,
  output logic             txPin,
  output logic             txTake,
  output logic [15:0]      rxLeft,
  output logic [15:0]      rxRight,
  output logic             rxValid,
  output logic             bclkFast,
  output logic             frameFast
);

  logic            bclkLevel;
  logic            bclkRise;
  logic            bclkFall;
  logic            wsLevel;
  logic            rxLevel;
  logic [15:0]     rxShift;
  logic [15:0]     txShift;
  logic [15:0]     txHold;
  logic            wsLast;
  logic [CNT_W-1:0] bclkCnt;
  logic [CNT_W-1:0] wsCnt;

  // all three pins cross into the mclk domain here
  isp_edge_sync u_bclk (
    .mclk  (mclk),
    .nrst  (nrst),
    .din   (bitClk),
    .level (bclkLevel),
    .rise  (bclkRise),
    .fall  (bclkFall)
  );

  // word select and data share the bit clock's delay, so they line up with its edges
  isp_edge_sync u_ws (
    .mclk  (mclk),
    .nrst  (nrst),
    .din   (wordSel),
    .level (wsLevel),
    .rise  (),
    .fall  ()
  );

  isp_edge_sync u_rx (
    .mclk  (mclk),
    .nrst  (nrst),
    .din   (rxPin),
    .level (rxLevel),
    .rise  (),
    .fall  ()
  );

  // format decode; codes outside the normal range leave the port idle except the bit clock watch, bclkFast
  wire fmtValid  = (formatCode >= FMT_FIRST) && (formatCode <= FMT_LAST);
  wire fmtOdd    = formatCode[0];
  wire rateValid = rateCode <= RATE_LAST;

  wire launchEdge = fmtValid & (fmtOdd ? bclkRise : bclkFall);

  wire sampleEdge = fmtValid & (fmtOdd ? bclkFall : bclkRise);

  // select change marks the slot's last bit; old select names the channel
  wire wsChange   = sampleEdge & (wsLevel != wsLast);
  wire leftDone   = wsChange & ~wsLast;
  wire rightDone  = wsChange & wsLast;
  wire [15:0] rxWord = {rxShift[14:0], rxLevel};

  // per-rate least periods in mclk cycles
  wire [3:0]       rateIdx  = rateValid ? rateCode : 4'h0;
  wire [CNT_W-1:0] bclkMin  = ns_to_cyc(BCLK_MIN_NS[rateIdx]);
  wire [CNT_W-1:0] wsMin    = ns_to_cyc(WS_MIN_NS[rateIdx]);
  // counts include the current cycle and saturate at CNT_MAX, so a stopped clock never wraps
  wire [CNT_W-1:0] bclkSeen = (bclkCnt == CNT_MAX) ? CNT_MAX : bclkCnt + 12'h001;
  wire [CNT_W-1:0] wsSeen   = (wsCnt == CNT_MAX) ? CNT_MAX : wsCnt + 12'h001;
  wire             frameEdge = leftDone;

  // receive shifter, one bit per sampling edge
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rxShift <= 16'h0000;
      wsLast  <= 1'b0;
    end else if (sampleEdge) begin
      rxShift <= rxWord;
      wsLast  <= wsLevel;
    end
  end

  // completed slots, left first, frame valid after right
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rxLeft  <= 16'h0000;
      rxRight <= 16'h0000;
      rxValid <= 1'b0;
    end else begin
      rxValid <= rightDone;
      if (leftDone) begin
        rxLeft <= rxWord;
      end
      if (rightDone) begin
        rxRight <= rxWord;
      end
    end
  end

  // load msb for the next launch, right word held for the whole frame
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      txShift <= 16'h0000;
      txHold  <= 16'h0000;
      txTake  <= 1'b0;
    end else begin
      txTake <= rightDone;
      if (rightDone) begin
        txShift <= txLeft;
        txHold  <= txRight;
      end else if (leftDone) begin
        txShift <= txHold;
      end else if (launchEdge) begin
        txShift <= {txShift[14:0], 1'b0};
      end
    end
  end

  // pin changes only on the launch edge, and is forced low while the format code is outside the normal range
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      txPin <= 1'b0;
    end else if (!fmtValid) begin
      txPin <= 1'b0;
    end else if (launchEdge) begin
      txPin <= txShift[15];
    end
  end

  // bit clock period watch, measured rise to rise
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bclkCnt  <= 12'h000;
      bclkFast <= 1'b0;
    end else if (bclkRise) begin
      bclkCnt  <= 12'h000;
      bclkFast <= rateValid & (bclkSeen < bclkMin);
    end else begin
      bclkCnt  <= bclkSeen;
    end
  end

  // frame period watch, measured between left slot ends
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wsCnt     <= 12'h000;
      frameFast <= 1'b0;
    end else if (frameEdge) begin
      wsCnt     <= 12'h000;
      frameFast <= rateValid & (wsSeen < wsMin);
    end else begin
      wsCnt     <= wsSeen;
    end
  end

endmodule
`default_nettype wire

// ===== isp_audio_slave_checker.sv
// checker: launch edges and frame pulses at the port pins
// assumes pins move just after an mclk edge and format changes only in reset
`timescale 1ns/1ns
`default_nettype none
module isp_audio_slave_checker (
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic       bitClk,
  input wire logic [3:0] formatCode,
  input wire logic       txPin,
  input wire logic       txTake,
  input wire logic       rxValid
);
  logic       clkQ;
  logic [3:0] sFall;
  logic [3:0] sRise;
  wire        fmtOk = formatCode >= 4'h2 && formatCode <= 4'hd;
  // cycles since each pin edge; saturate so idle gaps never wrap
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clkQ  <= 1'b0;
      sFall <= 4'hf;
      sRise <= 4'hf;
    end else begin
      clkQ  <= bitClk;
      sFall <= (clkQ && !bitClk) ? 4'h0 : sFall + 4'(sFall != 4'hf);
      sRise <= (!clkQ && bitClk) ? 4'h0 : sRise + 4'(sRise != 4'hf);
    end
  end
  // tx moves only a sync delay after the launch edge of the chosen code
  a_tx_even_edge: assert property (@(posedge mclk) disable iff (!nrst)
    fmtOk && !formatCode[0] && $changed(txPin) |-> sFall inside {[4'h1:4'h4]})
    else $error("tx moved off the fall");
  a_tx_odd_edge: assert property (@(posedge mclk) disable iff (!nrst)
    fmtOk && formatCode[0] && $changed(txPin) |-> sRise inside {[4'h1:4'h4]})
    else $error("tx moved off the rise");
  a_frame_pair: assert property (@(posedge mclk) disable iff (!nrst)
    rxValid |-> txTake) else $error("frame end without tx take");
  a_frame_gap: assert property (@(posedge mclk) disable iff (!nrst)
    rxValid |=> !rxValid [*8]) else $error("frame end repeated");
  a_idle_quiet: assert property (@(posedge mclk) disable iff (!nrst)
    !fmtOk |-> !txPin && !rxValid) else $error("activity with no format");
endmodule
bind isp_audio_slave isp_audio_slave_checker i_chk (.mclk, .nrst, .bitClk, .formatCode,
  .txPin, .txTake, .rxValid);
`default_nettype wire

// ===== isp_master_model.sv
// master model: bit clock and select source, one frame per call
// assumes the bench parks the clock in reset; it stands still between frames
`timescale 1ns/1ns
`default_nettype none
module isp_master_model (
  output logic      bitClk,
  output logic      wordSel,
  output logic      rxPin,
  input  wire logic txPin
);
  logic [31:0] got = '0;
  initial {bitClk, wordSel, rxPin} = 3'b100;
  // idle level is the one before the launch edge
  task automatic park(input logic odd);
    bitClk = !odd;
  endtask
  // 32 clocks, select moves with the last bit of each slot
  task automatic frame(input logic odd, input logic [31:0] fw);
    for (int k = 1; k <= 32; k++) begin
      wordSel = k >= 16 && k < 32;
      rxPin = fw[32-k];
      // launch opposite the sampling edge, faster than every limit
      bitClk = odd;
      #160 bitClk = !odd;
      #150 got = {got[30:0], txPin};
      #10;
    end
    // a released line shows its inverse
    rxPin = !rxPin;
  endtask
endmodule
`default_nettype wire

// ===== tb_isp_audio_slave.sv
// bench: random frames for every format code against the master model
// assumes the model owns the link pins; the bench drives codes and tx words
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
  $display("MISMATCH %0t %h %h", $time, a, b); end end
module tb_isp_audio_slave import isp_pkg::*; ;
  logic        mclk, nrst, seen;
  logic [3:0]  formatCode, rateCode;
  logic [15:0] txLeft, txRight;
  logic [31:0] fw, expTx;
  int          n_errors, samples_checked;
  wire         bitClk, wordSel, rxPin, txPin, txTake, rxValid, bclkFast, frameFast;
  wire  [15:0] rxLeft, rxRight;
  isp_audio_slave i_dut (.mclk, .nrst, .bitClk, .wordSel, .rxPin, .formatCode, .rateCode,
    .txLeft, .txRight, .txPin, .txTake, .rxLeft, .rxRight, .rxValid, .bclkFast, .frameFast);
  isp_master_model i_mst (.bitClk, .wordSel, .rxPin, .txPin);
  function automatic logic ok(input logic [3:0] c);
    return c >= FMT_FIRST && c <= FMT_LAST;
  endfunction
  initial begin
    mclk = 1'b0;
    forever #20 mclk = !mclk;
  end
  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // watchdog well past 16 codes of three frames
  initial begin
    #2000000;
    n_errors++;
    end_sim();
  end
  // every code, refused ones too; first frame after reset only primes
  initial begin
    {nrst, formatCode, rateCode, txLeft, txRight, n_errors, samples_checked} = '0;
    void'($urandom(32'h9cb1));
    for (int c = 0; c < 16; c++) begin
      @(posedge mclk);
      #1 nrst = 1'b0;
      formatCode = 4'(c);
      rateCode = 4'($urandom_range(8));
      i_mst.park(c[0]);
      repeat (3) @(posedge mclk);
      #1 nrst = 1'b1;
      for (int n = 0; n < 3; n++) begin
        fw = $urandom;
        seen = 1'b0;
        fork
          i_mst.frame(c[0], fw);
          for (int w = 0; w < 300 && !seen; w++) begin
            @(posedge mclk);
            #1 seen = rxValid;
          end
        join
        if (n > 0) begin
          `CHK(i_mst.got, ok(formatCode) ? expTx : '0)
          `CHK({rxLeft, rxRight}, ok(formatCode) ? fw : '0)
          `CHK(seen, ok(formatCode))
        end
        if (n == 2 && ok(formatCode)) `CHK({bclkFast, frameFast}, 2'b11)
        expTx = {txLeft, txRight};
        @(posedge mclk);
        #1 {txLeft, txRight} = $urandom;
      end
    end
    end_sim();
  end
endmodule
`default_nettype wire
